// file: hw/pmwc_ctrl.sv
// Power mode and wake-up controller top level
`timescale 1ns/10ps
`include "pmwc_defines.svh"
module pmwc_ctrl
	import pmwc_pkg::*;
#(
	parameter int PA_W = 8,
	parameter int IRQ_W = 4,
	parameter int SST_W = 11
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	// Instruction events
	input wire logic halt_exec,
	input wire logic clr_wdt_exec,
	// Oscillators
	input wire logic hs_is_crystal,
	input wire logic hosc_tick,
	input wire logic losc_tick,
	// Watchdog and voltage detector
	input wire logic wdt_enable,
	input wire logic lvd_enable,
	input wire logic wdt_overflow,
	// Wake sources
	input wire logic ext_reset_req,
	input wire logic [PA_W-1:0] port_a,
	input wire logic [IRQ_W-1:0] irq_flags,
	input wire logic [IRQ_W-1:0] irq_enable,
	input wire logic stack_full,
	// Clock controls
	output logic hosc_run,
	output logic hdiv_run,
	output logic sub_clk_run,
	output logic sys_clk_run,
	output logic sys_clk_low,
	// Core controls
	output logic cpu_stall,
	output logic wdt_clear,
	output logic wdt_run,
	output logic full_reset,
	output logic pc_sp_reset,
	output logic resume_next,
	output logic irq_service
);
	logic [7:0] mode_ff;
	logic [7:0] ext_ff;
	logic [7:0] wake_en_ff;
	logic [7:0] rdata_ff;
	pmwc_state_e st_ff;
	pmwc_state_e nxt_st;
	pmwc_state_e halt_tgt;
	logic pdf_ff;
	logic to_ff;
	logic hrdy_ff;
	logic lrdy_ff;
	logic sel_low_ff;
	logic nxt_sel_low;
	logic own_low_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic [PA_W-1:0] pa_fall;
	logic sst_busy;
	logic sst_done;

	// Mode decode
	wire high_low_clock_select = mode_ff[`PMWC_MODE_HIGH_LOW_CLOCK_SELECT];
	wire idle_en = mode_ff[`PMWC_MODE_IDLE_ENABLE_BIT];
	wire fast_wake_enable = mode_ff[`PMWC_MODE_FAST_WAKE_ENABLE];
	wire idle_sysclk_on_bit = ext_ff[`PMWC_EXT_IDLE_SYSCLK_ON_BIT];
	wire [2:0] div = mode_ff[`PMWC_MODE_DIV_MSB:`PMWC_MODE_DIV_LSB];
	wire slow_req = !high_low_clock_select && (div <= `PMWC_DIV_SLOW_MAX);

	// State decode
	wire is_run = st_ff == st_run;
	wire active = is_run || st_ff == st_wake;
	wire lp = !active;
	wire wd_or_lvd = wdt_enable || lvd_enable;
	wire halt_go = is_run && halt_exec;

	// Target chosen from bits as they stand at the halt
	assign halt_tgt = idle_en ? (idle_sysclk_on_bit ? st_idle_clock_on_state : st_idle_clock_off_state)
		: (wd_or_lvd ? st_sleepl : st_sleepd);

	// Wake sources
	pmwc_fedge #(.W(PA_W)) u_pa_edge (
		.clk(clk),
		.rst_n(rst_n),
		.pins(port_a),
		.en(wake_en_ff[PA_W-1:0]),
		.fall(pa_fall)
	);

	// Requests already pending at entry are masked from waking
	wire [IRQ_W-1:0] irq_new = irq_flags & ~irq_mask_ff;
	wire pa_wake = |pa_fall;
	wire irq_wake = |irq_new;
	wire irq_take = (|(irq_new & irq_enable)) && !stack_full;
	wire wdt_ev = wdt_overflow && wdt_run;
	wire wake = lp && (ext_reset_req || pa_wake || irq_wake || wdt_ev);
	wire plain_wake = wake && !ext_reset_req && !wdt_ev;
	wire fast_ok = fast_wake_enable && hs_is_crystal && !slow_req && !sel_low_ff
		&& lrdy_ff && (st_ff == st_sleepl || st_ff == st_idle_clock_off_state);
	wire run_ok = sel_low_ff ? lrdy_ff : hrdy_ff;

	// Operating state sequence
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			st_run: begin
				if (halt_go) begin
					nxt_st = halt_tgt;
				end
			end
			st_sleepd, st_sleepl, st_idle_clock_off_state, st_idle_clock_on_state: begin
				if (wake) begin
					nxt_st = st_wake;
				end
			end
			st_wake: begin
				if (run_ok) begin
					nxt_st = st_run;
				end
			end
			default: begin
				nxt_st = st_wake;
			end
		endcase
	end

	// System clock source select
	always_comb begin
		nxt_sel_low = sel_low_ff;
		if (wake && fast_ok) begin
			nxt_sel_low = 1'b1;
		end else if (active) begin
			if (slow_req && lrdy_ff) begin
				nxt_sel_low = 1'b1;
			end else if (!slow_req && hrdy_ff) begin
				nxt_sel_low = 1'b0;
			end
		end
	end

	// Clock controls
	assign sys_clk_run = active || st_ff == st_idle_clock_on_state;
	assign hosc_run = sys_clk_run && !(sel_low_ff && slow_req);
	assign hdiv_run = hosc_run;
	assign sub_clk_run = st_ff != st_sleepd;
	assign sys_clk_low = sel_low_ff;

	// Core controls; execution only in the run state
	assign cpu_stall = !is_run;
	assign wdt_clear = halt_go || clr_wdt_exec;
	assign wdt_run = wdt_enable && sub_clk_run;
	assign full_reset = lp && ext_reset_req;
	assign pc_sp_reset = lp && wdt_ev && !ext_reset_req;
	assign irq_service = plain_wake && irq_take;
	assign resume_next = plain_wake && !irq_take;

	// Shared start-up timer: high crystal always claims it first
	wire hs_need = hosc_run && !hrdy_ff;
	wire ls_need = sub_clk_run && !lrdy_ff;
	// Hold off while done stands so a finished owner is not timed again
	wire sst_start = !sst_busy && !sst_done
		&& (hs_need || ls_need);
	// A waiting high crystal pre-empts a low crystal period in progress
	wire sst_abort = sst_busy && (own_low_ff ? (!sub_clk_run || hs_need)
		: !hosc_run);

	pmwc_sst #(.CW(SST_W)) u_sst (
		.clk(clk),
		.rst_n(rst_n),
		.start(sst_start),
		.abort(sst_abort),
		.tick(own_low_ff ? losc_tick : hosc_tick),
		.busy(sst_busy),
		.done(sst_done)
	);

	// Register read decode
	wire [7:0] mode_rd = (mode_ff & `PMWC_MODE_WMASK)
		| (8'(hrdy_ff) << `PMWC_MODE_HRDY)
		| (8'(lrdy_ff) << `PMWC_MODE_LRDY);
	wire [7:0] status_rd = {2'h0, sel_low_ff, st_ff, pdf_ff, to_ff};
	wire [7:0] rd_mux = (addr == `PMWC_ADDR_MODE) ? mode_rd
		: (addr == `PMWC_ADDR_MODE_EXT) ? (ext_ff & `PMWC_EXT_WMASK)
		: (addr == `PMWC_ADDR_STATUS) ? status_rd
		: (addr == `PMWC_ADDR_WAKE_EN) ? wake_en_ff
		: 8'h00;
	wire wr_mode = wr_en && addr == `PMWC_ADDR_MODE;
	wire wr_ext = wr_en && addr == `PMWC_ADDR_MODE_EXT;
	wire wr_wake = wr_en && addr == `PMWC_ADDR_WAKE_EN;

	// Flags: a set in the same cycle as a clear wins
	wire nxt_pdf = halt_go || (pdf_ff && !clr_wdt_exec);
	wire nxt_to = wdt_ev || (to_ff && !halt_go);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_ff <= `PMWC_MODE_RST;
			ext_ff <= `PMWC_EXT_RST;
			wake_en_ff <= `PMWC_WAKE_EN_RST;
		end else begin
			if (wr_mode) begin
				mode_ff <= wdata & `PMWC_MODE_WMASK;
			end
			if (wr_ext) begin
				ext_ff <= wdata & `PMWC_EXT_WMASK;
			end
			if (wr_wake) begin
				wake_en_ff <= wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= rd_en ? rd_mux : 8'h00;
		end
	end

	// Power-up behaves like a deep sleep wake: wait for the crystal
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= st_wake;
			sel_low_ff <= 1'b0;
			pdf_ff <= 1'b0;
			to_ff <= 1'b0;
			irq_mask_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			sel_low_ff <= nxt_sel_low;
			pdf_ff <= nxt_pdf;
			to_ff <= nxt_to;
			if (halt_go) begin
				irq_mask_ff <= irq_flags;
			end
		end
	end

	// Ready flags drop as soon as their oscillator stops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdy_ff <= 1'b0;
			lrdy_ff <= 1'b0;
			own_low_ff <= 1'b0;
		end else begin
			if (sst_start) begin
				own_low_ff <= !hs_need;
			end
			hrdy_ff <= hosc_run && (hrdy_ff || (sst_done && !own_low_ff));
			lrdy_ff <= sub_clk_run && (lrdy_ff || (sst_done && own_low_ff));
		end
	end

	assign rdata = rdata_ff;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	slow_entry_a: assert property (
		(active && slow_req && lrdy_ff) |=> sel_low_ff)
		else $error("slow mode not entered with low clock ready");
	normal_return_a: assert property (
		(active && !slow_req && !sel_low_ff && !hrdy_ff) |=> !sel_low_ff)
		else $error("normal mode left before high ready");
	hosc_stop_a: assert property (
		(sel_low_ff && slow_req) |-> (!hosc_run && !hdiv_run))
		else $error("high oscillator runs in slow mode");
	deep_sleep_a: assert property (
		(halt_go && !idle_en && !wd_or_lvd)
		|=> (st_ff == st_sleepd && !sub_clk_run && !sys_clk_run))
		else $error("deep sleep not entered");
	light_sleep_a: assert property (
		(halt_go && !idle_en && wd_or_lvd)
		|=> (st_ff == st_sleepl && sub_clk_run && !sys_clk_run))
		else $error("light sleep not entered");
	idle_off_a: assert property (
		(halt_go && idle_en && !idle_sysclk_on_bit)
		|=> (st_ff == st_idle_clock_off_state && sub_clk_run && !sys_clk_run))
		else $error("idle clock-off state not entered");
	idle_on_a: assert property (
		(halt_go && idle_en && idle_sysclk_on_bit)
		|=> (st_ff == st_idle_clock_on_state && sub_clk_run && sys_clk_run))
		else $error("idle clock-on state not entered");
	lp_stall_a: assert property (
		lp |-> cpu_stall)
		else $error("core not stalled in low power");
	halt_flags_a: assert property (
		(halt_go && !wdt_ev) |=> (pdf_ff && !to_ff))
		else $error("flags wrong after halt");
	halt_wdt_a: assert property (
		halt_go |-> wdt_clear ##1 (st_ff != st_sleepd || !wdt_run))
		else $error("watchdog not cleared or not stopped");
	ext_wake_a: assert property (
		(lp && ext_reset_req) |-> full_reset ##1 (st_ff == st_wake))
		else $error("external reset wake missed");
	wdt_wake_a: assert property (
		(lp && wdt_ev && !ext_reset_req) |-> pc_sp_reset ##1 to_ff)
		else $error("watchdog wake did not set timeout");
	irq_wake_a: assert property (
		plain_wake |-> (irq_service != resume_next)
		&& (irq_service == irq_take))
		else $error("wake response wrong");
	old_irq_a: assert property (
		(lp && !ext_reset_req && !wdt_ev && !pa_wake && !irq_wake)
		|=> (st_ff == $past(st_ff)))
		else $error("woken by a pending interrupt");
	sst_share_a: assert property (
		(sst_busy && own_low_ff && hs_need) |=> !sst_busy)
		else $error("low crystal timed before high crystal");
	sst_order_a: assert property (
		(sst_start && hs_need) |=> !own_low_ff)
		else $error("start-up timer not given to high crystal");
	deep_wake_a: assert property (
		(st_ff == st_wake && !sel_low_ff && !hrdy_ff) |=> cpu_stall)
		else $error("execution before high ready");
	fast_wake_a: assert property (
		(wake && fast_ok) |=> sel_low_ff ##1 !cpu_stall)
		else $error("fast wake did not run from sub clock");
	irq_mask_a: assert property (
		halt_go |=> (irq_mask_ff == $past(irq_flags)))
		else $error("pending requests not masked at halt");
	pdf_clear_a: assert property (
		(clr_wdt_exec && !halt_go) |=> !pdf_ff)
		else $error("power-down flag not cleared");
	pin_resume_a: assert property (
		(plain_wake && pa_wake && !irq_wake) |-> resume_next)
		else $error("pin wake did not resume after halt");

	deep_cycle_c: cover property (
		(st_ff == st_sleepd && wake) ##1 (st_ff == st_wake && hosc_run));
	fast_wake_c: cover property (
		(wake && fast_ok) ##1 sel_low_ff ##1 (is_run && sel_low_ff));
	idle_on_c: cover property (st_ff == st_idle_clock_on_state && wake);
	irq_service_c: cover property (irq_service);
	slow_mode_c: cover property (is_run && sel_low_ff && !hosc_run);
endmodule

// file: hw/pmwc_defines.svh
// Constants of the power mode and wake-up controller
`ifndef PMWC_DEFINES_SVH
`define PMWC_DEFINES_SVH

`define PMWC_ADDR_MODE 4'h0
`define PMWC_ADDR_MODE_EXT 4'h1
`define PMWC_ADDR_STATUS 4'h2
`define PMWC_ADDR_WAKE_EN 4'h3

`define PMWC_MODE_HIGH_LOW_CLOCK_SELECT 0
`define PMWC_MODE_IDLE_ENABLE_BIT 1
`define PMWC_MODE_HRDY 2
`define PMWC_MODE_LRDY 3
`define PMWC_MODE_FAST_WAKE_ENABLE 4
`define PMWC_MODE_DIV_LSB 5
`define PMWC_MODE_DIV_MSB 7
`define PMWC_MODE_WMASK 8'hf3
`define PMWC_EXT_IDLE_SYSCLK_ON_BIT 7
`define PMWC_EXT_WMASK 8'h80

`define PMWC_DIV_SLOW_MAX 3'h1

`define PMWC_MODE_RST 8'h01
`define PMWC_EXT_RST 8'h00
`define PMWC_WAKE_EN_RST 8'h00

`define PMWC_SST_CYCLES 1024

`endif

// file: hw/pmwc_pkg.sv
// Types of the power mode and wake-up controller
package pmwc_pkg;

	typedef enum logic [2:0] {
		st_run = 3'h0,
		st_idle_clock_on_state = 3'h1,
		st_idle_clock_off_state = 3'h3,
		st_sleepl = 3'h2,
		st_sleepd = 3'h6,
		st_wake = 3'h4
	} pmwc_state_e;

endpackage

// file: hw/pmwc_sst.sv
// Shared oscillator start-up timer
`timescale 1ns/10ps
`include "pmwc_defines.svh"
module pmwc_sst #(
	parameter int CW = 11,
	parameter logic [CW-1:0] LIMIT = CW'(`PMWC_SST_CYCLES)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic tick,
	// Status
	output logic busy,
	output logic done
);
	logic [CW-1:0] cnt_ff;
	logic busy_ff;
	logic done_ff;
	wire last = busy_ff && tick && (cnt_ff == LIMIT - CW'(1));

	always_ff @(posedge clk) begin
		if (!rst_n || abort) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= last;
			if (start && !busy_ff) begin
				busy_ff <= 1'b1;
				cnt_ff <= '0;
			end else if (last) begin
				busy_ff <= 1'b0;
			end else if (busy_ff && tick) begin
				cnt_ff <= cnt_ff + CW'(1);
			end
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
endmodule

// file: hw/pmwc_fedge.sv
// Per-pin falling edge detector with enables
`timescale 1ns/10ps
module pmwc_fedge #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins and enables
	input wire logic [W-1:0] pins,
	input wire logic [W-1:0] en,
	// Detected edges
	output logic [W-1:0] fall
);
	logic [W-1:0] prev_ff;

	// Idle pins sit high, so reset to ones avoids a false edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_ff <= '1;
		end else begin
			prev_ff <= pins;
		end
	end

	assign fall = prev_ff & ~pins & en;
endmodule

// file: bench/pmwc_osc_model.sv
// Oscillator model that feeds tick pulses to the mode controller
`timescale 1ns/10ps
module pmwc_osc_model #(
	parameter int HDIV = 2,
	parameter int LDIV = 4
) (
	// Clock
	input wire logic clk,
	// Oscillator enables
	input wire logic hosc_run,
	input wire logic sub_clk_run,
	// Tick pulses
	output logic hosc_tick,
	output logic losc_tick
);
	int hcnt = 0;
	int lcnt = 0;
	// A stopped oscillator gives no ticks and restarts from phase zero
	always @(posedge clk) begin
		hcnt <= hosc_run ? (hcnt + 1) % HDIV : 0;
		lcnt <= sub_clk_run ? (lcnt + 1) % LDIV : 0;
		hosc_tick <= hosc_run && hcnt == HDIV - 1;
		losc_tick <= sub_clk_run && lcnt == LDIV - 1;
	end
endmodule

// file: bench/tb_pmwc_ctrl.sv
// Self-checking bench of the power mode and wake-up controller
`timescale 1ns/10ps
`include "pmwc_defines.svh"
module tb_pmwc_ctrl;
	import pmwc_pkg::*;
	localparam logic [3:0] A_MD = `PMWC_ADDR_MODE;
	localparam logic [3:0] A_EX = `PMWC_ADDR_MODE_EXT;
	localparam logic [3:0] A_ST = `PMWC_ADDR_STATUS;
	localparam logic [3:0] A_WK = `PMWC_ADDR_WAKE_EN;
	logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, d, port_a = 8'hff;
	logic halt_exec = 1'b0, clr_wdt_exec = 1'b0, hs_is_crystal = 1'b1;
	logic hosc_tick, losc_tick, wdt_enable = 1'b0, lvd_enable = 1'b0;
	logic wdt_overflow = 1'b0, ext_reset_req = 1'b0, stack_full = 1'b0;
	logic [3:0] irq_flags = 4'h0, irq_enable = 4'hf, seen = 4'h0;
	logic hosc_run, hdiv_run, sub_clk_run, sys_clk_run, sys_clk_low;
	logic cpu_stall, wdt_clear, wdt_run, full_reset, pc_sp_reset;
	logic resume_next, irq_service;
	int err_count = 0;
	int num_checks = 0;
	pmwc_state_e stt[5] = '{st_sleepd, st_sleepl, st_sleepl, st_idle_clock_off_state,
		st_idle_clock_on_state};
	logic [4:0] ie = 5'h18, fs = 5'h10, we = 5'h02, le = 5'h04;
	logic [4:0] sr = 5'h10, ur = 5'h1e;

	always #20 clk = ~clk;

	pmwc_ctrl u_pmwc_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec),
		.hs_is_crystal(hs_is_crystal), .hosc_tick(hosc_tick),
		.losc_tick(losc_tick), .wdt_enable(wdt_enable),
		.lvd_enable(lvd_enable), .wdt_overflow(wdt_overflow),
		.ext_reset_req(ext_reset_req), .port_a(port_a),
		.irq_flags(irq_flags), .irq_enable(irq_enable),
		.stack_full(stack_full), .hosc_run(hosc_run), .hdiv_run(hdiv_run),
		.sub_clk_run(sub_clk_run), .sys_clk_run(sys_clk_run),
		.sys_clk_low(sys_clk_low), .cpu_stall(cpu_stall),
		.wdt_clear(wdt_clear), .wdt_run(wdt_run), .full_reset(full_reset),
		.pc_sp_reset(pc_sp_reset), .resume_next(resume_next),
		.irq_service(irq_service));

	pmwc_osc_model u_pmwc_osc_model (.clk(clk), .hosc_run(hosc_run),
		.sub_clk_run(sub_clk_run), .hosc_tick(hosc_tick),
		.losc_tick(losc_tick));

	// Sticky record of wake outcomes, so pulse timing need not be guessed
	always @(posedge clk) begin
		seen <= halt_exec ? 4'h0
			: seen | {full_reset, pc_sp_reset, irq_service, resume_next};
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task stop_test;
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		// Before its update this edge still shows the read cycle's data
		@(posedge clk);
		d = rdata;
	endtask

	// Bounded wait on cpu_stall (sel 0) or sys_clk_low (sel 1)
	task wait_for(input bit sel, input logic v);
		int n;
		n = 0;
		while ((sel ? sys_clk_low : cpu_stall) !== v && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			err_count++;
			stop_test;
		end
	endtask

	task do_halt(input logic [7:0] m, input logic [7:0] x);
		wr(A_MD, m);
		wr(A_EX, x);
		@(posedge clk);
		halt_exec <= 1'b1;
		@(posedge clk);
		chk({7'h0, wdt_clear}, 8'h01);
		halt_exec <= 1'b0;
		// One more edge so the caller sees the settled low-power state
		@(posedge clk);
	endtask

	task wake_pin(input int i);
		@(posedge clk);
		port_a <= ~(8'h01 << i);
		wait_for(0, 1'b0);
		port_a <= 8'hff;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_ST);
		chk(d, {3'h0, 3'(st_wake), 2'h0});
		rd(A_MD);
		chk(d, 8'h01);
		rd(A_WK);
		chk(d, 8'h00);
		wr(4'h9, 8'hff);
		rd(4'h9);
		chk(d, 8'h00);
		wait_for(0, 1'b0);
		$display("done: reset");
		for (int c = 0; c < 8; c++) begin
			wr(A_MD, {3'(c), 5'h00});
			if (c == 2) begin
				@(posedge clk);
				chk({7'h0, hosc_run}, 8'h01);
			end
			wait_for(1, c < 2);
			rd(A_ST);
			chk(d & 8'h20, c < 2 ? 8'h20 : 8'h00);
			if (c < 2)
				chk({6'h0, hosc_run, hdiv_run}, 8'h00);
		end
		rd(A_MD);
		chk(d, 8'hec);
		$display("done: clock modes");
		wdt_enable <= 1'b1;
		wr(A_WK, 8'h01);
		do_halt(8'h11, 8'h00);
		wake_pin(0);
		chk({7'h0, sys_clk_low}, 8'h01);
		wait_for(1, 1'b0);
		rd(A_MD);
		chk(d & 8'h04, 8'h04);
		$display("done: fast wake");
		for (int i = 0; i < 5; i++) begin
			wdt_enable <= we[i];
			lvd_enable <= le[i];
			wr(A_WK, 8'h01 << i);
			do_halt({6'h0, ie[i], 1'b1}, {fs[i], 7'h0});
			chk({4'h0, cpu_stall, sys_clk_run, sub_clk_run, wdt_run},
				{5'h01, sr[i], ur[i], we[i] & ur[i]});
			rd(A_ST);
			chk(d, {3'h0, 3'(stt[i]), 2'h2});
			wake_pin(i);
			chk({4'h0, seen}, 8'h01);
			rd(A_MD);
			chk(d & 8'h04, 8'h04);
			rd(A_ST);
			chk(d, 8'h02);
			@(posedge clk);
			clr_wdt_exec <= 1'b1;
			@(posedge clk);
			clr_wdt_exec <= 1'b0;
			rd(A_ST);
			chk(d, 8'h00);
		end
		$display("done: halt states");
		wdt_enable <= 1'b1;
		lvd_enable <= 1'b0;
		do_halt(8'h01, 8'h00);
		@(posedge clk);
		wdt_overflow <= 1'b1;
		@(posedge clk);
		wdt_overflow <= 1'b0;
		wait_for(0, 1'b0);
		chk({4'h0, seen}, 8'h04);
		rd(A_ST);
		chk(d, 8'h03);
		$display("done: watchdog wake");
		irq_flags <= 4'h2;
		do_halt(8'h01, 8'h00);
		repeat (20) @(posedge clk);
		rd(A_ST);
		chk(d, 8'h0a);
		irq_flags <= 4'h3;
		wait_for(0, 1'b0);
		chk({4'h0, seen}, 8'h02);
		irq_flags <= 4'h0;
		stack_full <= 1'b1;
		do_halt(8'h01, 8'h00);
		irq_flags <= 4'h1;
		wait_for(0, 1'b0);
		chk({4'h0, seen}, 8'h01);
		irq_flags <= 4'h0;
		stack_full <= 1'b0;
		$display("done: interrupt wake");
		do_halt(8'h01, 8'h00);
		ext_reset_req <= 1'b1;
		@(posedge clk);
		ext_reset_req <= 1'b0;
		wait_for(0, 1'b0);
		chk({4'h0, seen}, 8'h08);
		$display("done: reset wake");
		stop_test;
	end
endmodule
